/* File: include/posn_status_pkg.sv */
// Shared constants and carriers for the positioning status block
package posn_status_pkg;

    // ****************************************
    // Widths and counts
    // ****************************************
    localparam int unsigned DIST_W        = 32;
    localparam int unsigned RANGE_W       = 16;
    localparam int unsigned SHIFT_W       = 32;
    localparam int unsigned ALARM_CODE_W  = 8;
    localparam int unsigned PAST_ALARMS   = 5;

    // ****************************************
    // Reset values and clear digit codes
    // ****************************************
    localparam logic [RANGE_W-1:0]      ROUGH_RANGE_RST  = 16'h0000;
    localparam logic [SHIFT_W-1:0]      HOME_SHIFT_RST   = 32'h0000_0000;
    localparam logic                    CLEAR_NONE       = 1'b0;
    localparam logic                    CLEAR_LOG        = 1'b1;
    localparam logic [ALARM_CODE_W-1:0] ALARM_NONE       = 8'h00;

    // ****************************************
    // Power-up sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        ST_POWERUP = 2'b00,
        ST_CLEAR   = 2'b01,
        ST_RUN     = 2'b10
    } seq_state_t;

    // Alarm log as seen by the host
    typedef struct packed {
        logic [ALARM_CODE_W-1:0]             current;
        logic [PAST_ALARMS*ALARM_CODE_W-1:0] past;
    } alarm_log_t;

    // Status flags towards the field network
    typedef struct packed {
        logic rough_match_flag;
        logic in_position_flag;
    } remote_flags_t;

endpackage

/* File: design/positioning_status.sv */
// Positioning status flags, home shift handling and alarm history log
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Log current alarm plus five past alarms
// - Clear digit: 0 keep, 1 clear log
// - Clear digit returns to 0 after clearing
// - Clear request acts only at next power-up
// - Rough match set when remaining within range
// - Rough range 0 to 65535 pulses
// - Home shift used only with absolute detection
// - Home shift not applied at home set
// - Large shift holds in-position off at power-on
module positioning_status
(
    input  wire logic                                     clock,
    input  wire logic                                     rst_n,
    input  wire logic                                     power_up,
    input  wire logic                                     absolute_mode,
    input  wire logic                                     home_set,
    input  wire logic [posn_status_pkg::DIST_W-1:0]       remaining_distance,
    input  wire logic [posn_status_pkg::DIST_W-1:0]       position_error,
    input  wire logic [posn_status_pkg::DIST_W-1:0]       in_position_range,
    input  wire logic [posn_status_pkg::RANGE_W-1:0]      rough_match_range_setting,
    input  wire logic [posn_status_pkg::SHIFT_W-1:0]      home_shift_setting,
    input  wire logic                                     clear_write,
    input  wire logic                                     clear_write_value,
    input  wire logic                                     alarm_event,
    input  wire logic [posn_status_pkg::ALARM_CODE_W-1:0] alarm_code,
    output logic                                          alarm_log_clear_setting,
    output logic [posn_status_pkg::SHIFT_W-1:0]           home_shift_distance,
    output posn_status_pkg::alarm_log_t                   alarm_log,
    output posn_status_pkg::remote_flags_t                flags
);

    localparam int unsigned CW = posn_status_pkg::ALARM_CODE_W;
    localparam int unsigned NP = posn_status_pkg::PAST_ALARMS;

    // ****************************************
    // Sequencer and held settings
    // ****************************************
    posn_status_pkg::seq_state_t          state_reg, state_next;
    logic                                 clear_reg, clear_next;
    logic [posn_status_pkg::SHIFT_W-1:0]  shift_reg, shift_next;
    logic                                 hold_inpos_reg, hold_inpos_next;
    logic [CW-1:0]                        log_reg [0:NP];
    logic [CW-1:0]                        log_next [0:NP];
    logic                                 rough_reg, rough_next;
    logic                                 inpos_reg, inpos_next;

    always_comb
    begin
        state_next      = state_reg;
        clear_next      = clear_reg;
        shift_next      = shift_reg;
        hold_inpos_next = hold_inpos_reg;
        // Setting is stored but acts only at power-up
        if (clear_write)
        begin
            clear_next = clear_write_value;
        end
        case (state_reg)
            posn_status_pkg::ST_POWERUP:
            begin
                // Shift latched here only, never at home set
                shift_next = absolute_mode ? home_shift_setting
                           : posn_status_pkg::HOME_SHIFT_RST;
                hold_inpos_next = absolute_mode &&
                    (home_shift_setting > in_position_range);
                state_next = (clear_reg == posn_status_pkg::CLEAR_LOG)
                           ? posn_status_pkg::ST_CLEAR
                           : posn_status_pkg::ST_RUN;
            end
            posn_status_pkg::ST_CLEAR:
            begin
                // Self-return beats a host write in this cycle
                clear_next = posn_status_pkg::CLEAR_NONE;
                state_next = posn_status_pkg::ST_RUN;
            end
            posn_status_pkg::ST_RUN:
            begin
                if (power_up)
                begin
                    state_next = posn_status_pkg::ST_POWERUP;
                end
                // Home set releases the power-on hold
                if (hold_inpos_reg && home_set)
                begin
                    hold_inpos_next = 1'b0;
                end
            end
            default:
            begin
                state_next = posn_status_pkg::ST_POWERUP;
            end
        endcase
    end

    // ****************************************
    // Sequencer registers
    // ****************************************
    // Reset acts as the first power-on
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg      <= posn_status_pkg::ST_POWERUP;
            clear_reg      <= posn_status_pkg::CLEAR_NONE;
            shift_reg      <= posn_status_pkg::HOME_SHIFT_RST;
            hold_inpos_reg <= 1'b0;
        end
        else
        begin
            state_reg      <= state_next;
            clear_reg      <= clear_next;
            shift_reg      <= shift_next;
            hold_inpos_reg <= hold_inpos_next;
        end
    end

    // ****************************************
    // Alarm history shift register
    // ****************************************
    always_comb
    begin
        for (int i = 0; i <= NP; i++)
        begin
            log_next[i] = log_reg[i];
        end
        if (state_reg == posn_status_pkg::ST_CLEAR)
        begin
            for (int i = 0; i <= NP; i++)
            begin
                log_next[i] = posn_status_pkg::ALARM_NONE;
            end
        end
        else if (alarm_event)
        begin
            // Entry 0 is current; older ones age toward NP
            log_next[0] = alarm_code;
            for (int i = 1; i <= NP; i++)
            begin
                log_next[i] = log_reg[i-1];
            end
        end
    end

    // ****************************************
    // Alarm history registers
    // ****************************************
    // Log survives power_up; only reset or a clear empties it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i <= NP; i++)
            begin
                log_reg[i] <= posn_status_pkg::ALARM_NONE;
            end
        end
        else
        begin
            for (int i = 0; i <= NP; i++)
            begin
                log_reg[i] <= log_next[i];
            end
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    logic [posn_status_pkg::DIST_W-1:0] rough_limit;
    assign rough_limit = {{(posn_status_pkg::DIST_W-
                           posn_status_pkg::RANGE_W){1'b0}},
                          rough_match_range_setting};

    always_comb
    begin
        // Unsigned compare: full 16-bit range usable
        rough_next = (remaining_distance <= rough_limit);
        inpos_next = (position_error <= in_position_range) &&
                     !hold_inpos_reg &&
                     (state_reg == posn_status_pkg::ST_RUN);
    end

    // Registered so the host never sees a compare glitch
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rough_reg <= 1'b0;
            inpos_reg <= 1'b0;
        end
        else
        begin
            rough_reg <= rough_next;
            inpos_reg <= inpos_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic [NP*CW-1:0] past_flat;

    assign alarm_log_clear_setting = clear_reg;
    assign home_shift_distance     = shift_reg;
    assign flags                   = {rough_reg, inpos_reg};
    assign alarm_log               = {log_reg[0], past_flat};

    // Newest past entry sits in the lowest byte
    genvar g;
    generate
        for (g = 1; g <= NP; g++)
        begin : g_past
            assign past_flat[(g-1)*CW +: CW] = log_reg[g];
        end
    endgenerate

endmodule

`default_nettype wire

/* File: test/positioning_status_assertions.sv */
// Port-level checks for the positioning status block
`timescale 1ns/1ps
`default_nettype none
module positioning_status_assertions (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        power_up,
    input wire logic        absolute_mode,
    input wire logic        home_set,
    input wire logic [31:0] remaining_distance,
    input wire logic [31:0] in_position_range,
    input wire logic [15:0] rough_match_range_setting,
    input wire logic [31:0] home_shift_setting,
    input wire logic        clear_write,
    input wire logic        clear_write_value,
    input wire logic        alarm_event,
    input wire logic [7:0]  alarm_code,
    input wire logic        alarm_log_clear_setting,
    input wire logic [31:0] home_shift_distance,
    input wire posn_status_pkg::alarm_log_t    alarm_log,
    input wire posn_status_pkg::remote_flags_t flags
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    rough_on_a:
    assert property (
        remaining_distance <= {16'h0000, rough_match_range_setting}
        |=> flags.rough_match_flag) else $error("rough flag low");
    rough_off_a:
    assert property (
        remaining_distance > {16'h0000, rough_match_range_setting}
        |=> !flags.rough_match_flag) else $error("rough flag high");
    clear_write_a:
    assert property (clear_write && !$past(power_up, 2) |=>
        alarm_log_clear_setting == $past(clear_write_value))
        else $error("clear setting not written");
    clear_defer_a:
    assert property (clear_write && !alarm_event && !$past(power_up, 2)
        |=> $stable(alarm_log)) else $error("log changed before power-up");
    log_clear_a:
    assert property (power_up && alarm_log_clear_setting |-> ##3
        alarm_log == '0 && !alarm_log_clear_setting) else $error("no clear");
    log_shift_a:
    assert property (alarm_event && !$past(power_up, 2) |=>
        alarm_log == {$past(alarm_code), $past(alarm_log.past[31:0]),
        $past(alarm_log.current)}) else $error("log shift wrong");
    shift_abs_a:
    assert property (power_up |-> ##2 home_shift_distance ==
        ($past(absolute_mode) ? $past(home_shift_setting) : 32'h0))
        else $error("shift distance wrong");
    shift_home_a:
    assert property (home_set && $past(rst_n) && !$past(power_up)
        |=> $stable(home_shift_distance))
        else $error("shift applied at home set");
    inpos_hold_a:
    assert property (power_up && absolute_mode && home_shift_setting >
        in_position_range ##1 !home_set [*3] |-> !flags.in_position_flag)
        else $error("in-position raised");
endmodule
bind positioning_status positioning_status_assertions
    positioning_status_assertions_inst (.clock, .rst_n, .power_up,
    .absolute_mode, .home_set, .remaining_distance, .in_position_range,
    .rough_match_range_setting, .home_shift_setting, .clear_write,
    .clear_write_value, .alarm_event, .alarm_code, .alarm_log_clear_setting,
    .home_shift_distance, .alarm_log, .flags);
`default_nettype wire

/* File: test/host_model.sv */
// Host side that programs the home shift setting
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic [31:0] value,
    output logic      [31:0] home_shift_setting
);
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            home_shift_setting <= 32'h0000_0000;
        else if (load)
            home_shift_setting <= value;
endmodule
`default_nettype wire

/* File: test/tb_positioning_status.sv */
// Self-checking bench for the positioning status block
`timescale 1ns/1ps
`default_nettype none
module tb_positioning_status;
    logic clock = 1'b0, rst_n = 1'b0, power_up = 1'b0, absolute_mode = 1'b0;
    logic home_set = 1'b0, clear_write = 1'b0, clear_write_value = 1'b0;
    logic alarm_event = 1'b0, load = 1'b0, alarm_log_clear_setting;
    logic [31:0] remaining_distance = 32'h0, position_error = 32'h0;
    logic [31:0] in_position_range = 32'h0, shift_value = 32'h0;
    logic [31:0] home_shift_setting, home_shift_distance;
    logic [15:0] rough_match_range_setting = 16'h0;
    logic [7:0]  alarm_code = 8'h00;
    posn_status_pkg::alarm_log_t    alarm_log;
    posn_status_pkg::remote_flags_t flags;
    int n_mismatch = 0, tests_run = 0;
    always #12.5 clock = ~clock;
    positioning_status positioning_status_inst (.clock, .rst_n, .power_up,
        .absolute_mode, .home_set, .remaining_distance, .position_error,
        .in_position_range, .rough_match_range_setting, .home_shift_setting,
        .clear_write, .clear_write_value, .alarm_event, .alarm_code,
        .alarm_log_clear_setting, .home_shift_distance, .alarm_log, .flags);
    host_model host_model_inst (.clock, .rst_n, .load, .value(shift_value),
        .home_shift_setting);
    // ****************************************
    // Helpers
    // ****************************************
    task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Power cycle, then wait out the sequencer
    task automatic power_cycle;
        power_up <= 1'b1;
        @(posedge clock);
        power_up <= 1'b0;
        repeat (5) @(posedge clock);
    endtask
    function automatic logic rough(logic [31:0] r, logic [15:0] g);
        return r <= {16'h0000, g};
    endfunction
    function automatic logic [47:0] push(logic [47:0] m, logic [7:0] c);
        return {c, m[31:0], m[47:40]};
    endfunction
    initial
    begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        conclude;
    end
    initial
    begin
        logic [47:0] m;
        logic [15:0] g;
        logic [31:0] s;
        logic        e;
        m = 48'h0;
        void'($urandom(37488));
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 40; i++)
        begin
            g = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
            rough_match_range_setting <= g;
            remaining_distance <= {16'h0, g} + 32'($urandom_range(2)) - 32'h1;
            repeat (2) @(posedge clock);
            e = rough(remaining_distance, g);
            cmp(flags.rough_match_flag, e);
        end
        for (int i = 0; i < 7; i++)
        begin
            alarm_code <= 8'($urandom_range(1, 255));
            alarm_event <= 1'b1;
            @(posedge clock);
            m = push(m, alarm_code);
        end
        alarm_event <= 1'b0;
        clear_write <= 1'b1;
        @(posedge clock);
        clear_write <= 1'b0;
        power_cycle();
        cmp(alarm_log, m);
        clear_write <= 1'b1;
        clear_write_value <= 1'b1;
        @(posedge clock);
        clear_write <= 1'b0;
        repeat (3) @(posedge clock);
        cmp(alarm_log_clear_setting, 1'b1);
        cmp(alarm_log, m);
        power_cycle();
        cmp(alarm_log, 48'h0);
        cmp(alarm_log_clear_setting, 1'b0);
        in_position_range <= 32'h0000_000A;
        position_error <= 32'($urandom_range(0, 10));
        shift_value <= 32'($urandom_range(11, 4095));
        load <= 1'b1;
        absolute_mode <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
        home_set <= 1'b1;
        @(posedge clock);
        home_set <= 1'b0;
        repeat (2) @(posedge clock);
        cmp(home_shift_distance, 32'h0);
        power_cycle();
        cmp(home_shift_distance, shift_value);
        cmp(flags.in_position_flag, 1'b0);
        // New setting plus home set: shift waits for power-up
        s = shift_value;
        shift_value <= shift_value + 32'h1;
        load <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
        home_set <= 1'b1;
        @(posedge clock);
        home_set <= 1'b0;
        repeat (2) @(posedge clock);
        cmp(home_shift_distance, s);
        cmp(flags.in_position_flag, 1'b1);
        power_cycle();
        cmp(home_shift_distance, s + 32'h1);
        cmp(flags.in_position_flag, 1'b0);
        absolute_mode <= 1'b0;
        power_cycle();
        cmp(home_shift_distance, 32'h0);
        cmp(flags.in_position_flag, 1'b1);
        // Mid-run reset acts as a first power-on
        alarm_code <= 8'h5A;
        alarm_event <= 1'b1;
        @(posedge clock);
        alarm_event <= 1'b0;
        rst_n <= 1'b0;
        @(posedge clock);
        cmp(alarm_log, 48'h0);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        e = rough(remaining_distance, g);
        cmp(flags.rough_match_flag, e);
        conclude;
    end
endmodule
`default_nettype wire
